// ===== esf_pkg.sv
// Constants, register map and carriers for the enable sequencer and fault flags.
// Assumes a single 20 MHz core clock and a word-aligned Avalon-MM register bus.
package esf_pkg;
   localparam int unsigned CLK_KHZ = 20000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = (CLK_KHZ * TICK_US) / 1000;
   localparam int unsigned SHORT_US = 1000;
   localparam int unsigned SHORT_CYC = (CLK_KHZ * SHORT_US + 999) / 1000;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_VOLT = 8'h04;
   localparam logic [7:0] ADDR_RISE = 8'h08;
   localparam logic [7:0] ADDR_FALL = 8'h0c;
   localparam logic [7:0] ADDR_RESET = 8'h10;
   localparam logic [7:0] ADDR_FLAGS = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;

   localparam int CTRL_ON_LSB = 0;
   localparam int CTRL_PIN_LSB = 8;
   localparam int CTRL_DUAL_BIT = 16;
   localparam int VOLT_B0_LSB = 0;
   localparam int VOLT_B1_LSB = 8;
   localparam int VOLT_L0_LSB = 16;
   localparam int VOLT_L1_LSB = 24;
   localparam int DLY_W = 24;
   localparam int RST_TRIG_BIT = 0;
   localparam int RST_MASK_BIT = 1;
   localparam int FLG_W = 14;
   localparam int FLG_OC_LSB = 0;
   localparam int FLG_SHORT_LSB = 4;
   localparam int FLG_TWARN = 8;
   localparam int FLG_TSD = 9;
   localparam int FLG_OVP = 10;
   localparam int FLG_GOOD_LSB = 11;
   localparam int FLG_RESET = 13;
   localparam int MSK_W = 9;
   localparam int MSK_OC_LSB = 0;
   localparam int MSK_TWARN = 4;
   localparam int MSK_RISE_LSB = 5;
   localparam int MSK_FALL_LSB = 7;
   localparam int STS_OC_LSB = 0;
   localparam int STS_TWARN = 4;
   localparam int STS_TSD = 5;
   localparam int STS_OVP = 6;
   localparam int STS_GOOD_LSB = 7;
   localparam int STS_EN_LSB = 11;

   localparam logic [5:0] ELAPSED_MAX = 6'h3f;
   // Delay code to milliseconds of the enable-pin timebase
   localparam logic [15:0][5:0] DELAY_TICKS = {6'h20, 6'h18, 6'h14, 6'h10, 6'h0e, 6'h0c,
      6'h0a, 6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

   typedef struct packed {
      logic en;
      logic supply_ok;
      logic [3:0] overcurrent;
      logic thermal_warn;
      logic thermal_sd;
      logic overvoltage;
      logic [3:0] good;
      logic [3:0] low;
   } esf_sense_t;

   typedef struct packed {
      logic [5:0] on;
      logic [5:0] pin_sel;
      logic dual;
      logic [1:0][7:0] buck_code;
      logic [1:0][4:0] lin_code;
      logic [5:0][3:0] rise;
      logic [5:0][3:0] fall;
      logic reset_mask;
      logic [FLG_W-1:0] flags;
      logic [MSK_W-1:0] mask;
   } esf_regs_t;

   localparam esf_regs_t REGS_RST = '0;

   typedef struct packed {
      logic [3:0] enable;
      logic [1:0][7:0] buck_code;
      logic [1:0][4:0] lin_code;
      logic aux_output_a;
      logic aux_output_b;
   } esf_drive_t;

   typedef struct packed {
      esf_regs_t regs;
      esf_sense_t s1;
      esf_sense_t s2;
      esf_sense_t s3;
      esf_sense_t clean;
      logic en_q;
      logic [5:0] seq_on;
      logic [15:0] prescale;
      logic [5:0] elapsed;
      logic [3:0][15:0] short_cnt;
      logic [1:0] good_q;
      logic soft_pend;
      logic note_pend;
      logic otp_load;
      logic wreq;
      logic [31:0] rdata;
      esf_drive_t drive;
      logic irq_n;
   } esf_state_t;
endpackage : esf_pkg

// ===== esf_top.sv
// Enable-pin sequencer, reset handling and fault flags of a power-management controller.
// Assumes asynchronous monitor inputs from the analog side and an Avalon-MM master.
// Operation
// - A buck follows the enable pin only when its on bit and pin select are 1.
// - Pin-controlled regulators run at their voltage codes while the pin is high.
// - After an enable rise, each pin-controlled regulator turns on after its rise delay.
// - After an enable fall, each pin-controlled regulator turns off after its fall delay.
// - Linear regulators use the same on bit plus pin select qualification.
// - A pin-controlled aux output rises after its own rise delay.
// - A pin-controlled aux output falls after its own fall delay.
// - Register enables act at once; delays apply only to pin transitions.
// - Writing 1 to the soft reset trigger starts a reset; the bit self-clears.
// - Soft reset turns all off, drops aux outputs, restores defaults, reloads OTP.
// - The bus interface is not reset by a soft reset.
// - Supply undervoltage turns all off, drops aux outputs and restores defaults.
// - Supply recovery performs power-on reset, loads OTP and starts per registers.
// - Events set flags; the interrupt pin stays low until all flags clear.
// - After fault shutdown or soft reset, set the reset flag unless masked.
// - The reset flag mask reloads from OTP at every reset.
// - Overcurrent sets a maskable sticky flag and live status; clear fails while active.
// - Buck output low for 1 ms disables it and sets its short flag.
// - Linear output low for 1 ms disables it and sets its short flag.
// - Thermal warning sets a maskable flag that cannot clear while warm.
// - Thermal shutdown or overvoltage turns all off and sets a persistent flag.
// - Buck good rise and fall each set the good flag, each under its mask.
// - Good status bits show live output validity.
// - In dual-phase mode the master phase registers control both phases.
module esf_top
   import esf_pkg::*;
#(
   parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYC),
   parameter logic [15:0] SHORT_CYCLES = 16'(SHORT_CYC)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Enable pin, monitors and OTP
   input wire esf_sense_t sense,
   input wire logic otp_reset_mask,
   // Regulator and pin drive
   output esf_drive_t drive,
   output logic irq_low_pin
);
   logic [1:0] rst_pipe;
   logic rst_n;
   esf_state_t s;
   esf_state_t next_s;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] w;
      w = '0;
      case (a)
         ADDR_CTRL: begin
            w[CTRL_ON_LSB +: 6] = s.regs.on;
            w[CTRL_PIN_LSB +: 6] = s.regs.pin_sel;
            w[CTRL_DUAL_BIT] = s.regs.dual;
         end
         ADDR_VOLT: begin
            w[VOLT_B0_LSB +: 8] = s.regs.buck_code[0];
            w[VOLT_B1_LSB +: 8] = s.regs.buck_code[1];
            w[VOLT_L0_LSB +: 5] = s.regs.lin_code[0];
            w[VOLT_L1_LSB +: 5] = s.regs.lin_code[1];
         end
         ADDR_RISE: w[DLY_W-1:0] = s.regs.rise;
         ADDR_FALL: w[DLY_W-1:0] = s.regs.fall;
         ADDR_RESET: w[RST_MASK_BIT] = s.regs.reset_mask;
         ADDR_FLAGS: w[FLG_W-1:0] = s.regs.flags;
         ADDR_MASK: w[MSK_W-1:0] = s.regs.mask;
         ADDR_STATUS: begin
            w[STS_OC_LSB +: 4] = s.clean.overcurrent;
            w[STS_TWARN] = s.clean.thermal_warn;
            w[STS_TSD] = s.clean.thermal_sd;
            w[STS_OVP] = s.clean.overvoltage;
            w[STS_GOOD_LSB +: 4] = s.clean.good;
            w[STS_EN_LSB +: 6] = {s.drive.aux_output_b, s.drive.aux_output_a, s.drive.enable};
         end
         default: ;
      endcase
      return w;
   endfunction : rd_word

   always_comb begin
      esf_sense_t c;
      logic fault;
      logic req;
      logic acc;
      logic edge_seen;
      logic [31:0] bm;
      logic [31:0] wd;
      logic [31:0] m;
      logic [5:0] tgt;
      logic [5:0] eff;
      logic [3:0] trip;
      logic [1:0] g_rise;
      logic [1:0] g_fall;
      logic [FLG_W-1:0] set;
      int k;
      c = s.clean;
      fault = c.thermal_sd | c.overvoltage;
      req = read | write;
      acc = req & ~s.wreq;
      edge_seen = c.en != s.en_q;
      bm = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
      wd = writedata & bm;
      m = (rd_word(address) & ~bm) | wd;
      tgt = '0;
      eff = '0;
      trip = '0;
      set = '0;
      g_rise = '0;
      g_fall = '0;
      k = 0;
      next_s = s;
      next_s.soft_pend = 1'b0;

      // Three-stage sampling; a change counts once stages two and three agree
      next_s.s1 = sense;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.clean = (s.s2 & s.s3) | (s.clean & (s.s2 ^ s.s3));

      // One wait state per access; the answer stands in the cycle waitrequest is low
      next_s.wreq = ~(req & s.wreq);
      if (req & s.wreq) begin
         next_s.rdata = read ? rd_word(address) : 32'h0;
      end
      if (acc & write) begin
         case (address)
            ADDR_CTRL: begin
               next_s.regs.on = m[CTRL_ON_LSB +: 6];
               next_s.regs.pin_sel = m[CTRL_PIN_LSB +: 6];
               next_s.regs.dual = m[CTRL_DUAL_BIT];
            end
            ADDR_VOLT: begin
               next_s.regs.buck_code[0] = m[VOLT_B0_LSB +: 8];
               next_s.regs.buck_code[1] = m[VOLT_B1_LSB +: 8];
               next_s.regs.lin_code[0] = m[VOLT_L0_LSB +: 5];
               next_s.regs.lin_code[1] = m[VOLT_L1_LSB +: 5];
            end
            ADDR_RISE: next_s.regs.rise = m[DLY_W-1:0];
            ADDR_FALL: next_s.regs.fall = m[DLY_W-1:0];
            ADDR_RESET: begin
               // Host may write the mask, but OTP overrides it at the next reset
               next_s.regs.reset_mask = m[RST_MASK_BIT];
               next_s.soft_pend = wd[RST_TRIG_BIT];
            end
            ADDR_FLAGS: next_s.regs.flags = s.regs.flags & ~wd[FLG_W-1:0];
            ADDR_MASK: next_s.regs.mask = m[MSK_W-1:0];
            default: ;
         endcase
      end

      // Timebase restarts on every pin edge so delays count from the edge itself
      if (edge_seen) begin
         next_s.en_q = c.en;
         next_s.elapsed = '0;
         next_s.prescale = '0;
      end else if (s.prescale == TICK_CYCLES - 16'h1) begin
         next_s.prescale = '0;
         if (s.elapsed != ELAPSED_MAX) begin
            next_s.elapsed = s.elapsed + 6'h1;
         end
      end else begin
         next_s.prescale = s.prescale + 16'h1;
      end
      for (int i = 0; i < 6; i++) begin
         tgt = s.en_q ? DELAY_TICKS[s.regs.rise[i]] : DELAY_TICKS[s.regs.fall[i]];
         if (!edge_seen && s.elapsed >= tgt) begin
            next_s.seq_on[i] = s.en_q;
         end
      end

      // Output low too long trips the regulator off
      for (int i = 0; i < 4; i++) begin
         if (s.drive.enable[i] && c.low[i]) begin
            if (s.short_cnt[i] == SHORT_CYCLES - 16'h1) begin
               trip[i] = 1'b1;
               next_s.short_cnt[i] = '0;
               next_s.regs.on[i] = 1'b0;
            end else begin
               next_s.short_cnt[i] = s.short_cnt[i] + 16'h1;
            end
         end else begin
            next_s.short_cnt[i] = '0;
         end
      end

      for (int i = 0; i < 6; i++) begin
         k = (s.regs.dual && i == 1) ? 0 : i;
         eff[i] = s.regs.on[k] & (~s.regs.pin_sel[k] | s.seq_on[k]) & ~fault;
         if (i < 4) begin
            eff[i] = eff[i] & ~trip[i] & ~(s.regs.dual && i == 1 ? trip[0] : 1'b0);
         end
      end

      // Flag sources; a set in the same cycle as a clear wins
      g_rise = c.good[1:0] & ~s.good_q;
      g_fall = ~c.good[1:0] & s.good_q;
      next_s.good_q = c.good[1:0];
      set[FLG_OC_LSB +: 4] = c.overcurrent & ~s.regs.mask[MSK_OC_LSB +: 4];
      set[FLG_SHORT_LSB +: 4] = trip;
      set[FLG_TWARN] = c.thermal_warn & ~s.regs.mask[MSK_TWARN];
      set[FLG_TSD] = c.thermal_sd;
      set[FLG_OVP] = c.overvoltage;
      set[FLG_GOOD_LSB +: 2] = (g_rise & ~s.regs.mask[MSK_RISE_LSB +: 2])
         | (g_fall & ~s.regs.mask[MSK_FALL_LSB +: 2]);
      if (s.otp_load) begin
         next_s.regs.reset_mask = otp_reset_mask;
         next_s.otp_load = 1'b0;
      end
      if (fault) begin
         next_s.note_pend = 1'b1;
      end else if (s.note_pend && !s.otp_load) begin
         next_s.note_pend = 1'b0;
         set[FLG_RESET] = ~s.regs.reset_mask;
      end
      next_s.regs.flags = next_s.regs.flags | set;

      next_s.drive.enable = eff[3:0];
      next_s.drive.aux_output_a = eff[4];
      next_s.drive.aux_output_b = eff[5];
      next_s.drive.buck_code[0] = s.regs.buck_code[0];
      next_s.drive.buck_code[1] = s.regs.dual ? s.regs.buck_code[0] : s.regs.buck_code[1];
      next_s.drive.lin_code = s.regs.lin_code;

      // Soft reset and undervoltage leave the bus fields alone
      if (s.soft_pend || !c.supply_ok) begin
         next_s.regs = REGS_RST;
         next_s.seq_on = '0;
         next_s.short_cnt = '0;
         next_s.drive = '0;
         next_s.otp_load = 1'b1;
         next_s.note_pend = 1'b1;
      end
      next_s.irq_n = ~|next_s.regs.flags;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.wreq <= 1'b1;
         s.otp_load <= 1'b1;
         s.note_pend <= 1'b1;
         s.irq_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign readdata = s.rdata;
   assign waitrequest = s.wreq;
   assign drive = s.drive;
   assign irq_low_pin = s.irq_n;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_irq_pending: assert property (irq_low_pin == (s.regs.flags == '0))
      else $error("interrupt pin disagrees with pending flags");
   a_fault_off: assert property ((s.clean.thermal_sd || s.clean.overvoltage)
      |=> (drive.enable == 4'h0 && !drive.aux_output_a && !drive.aux_output_b))
      else $error("outputs stayed on during a fault");
   a_uvlo_default: assert property (!s.clean.supply_ok |=> (s.regs.on == 6'h0
      && s.regs.flags == '0 && drive.enable == 4'h0))
      else $error("undervoltage did not restore defaults");
   a_soft_reset: assert property ((!waitrequest && write && address == ADDR_RESET
      && byteenable[0] && writedata[RST_TRIG_BIT]) |=> s.soft_pend ##1
      (s.regs.on == 6'h0 && drive.enable == 4'h0 && s.otp_load))
      else $error("soft reset did not clear the block");
   a_seq_rise: assert property ((s.clean.en && !s.en_q && s.regs.on[0] && s.regs.pin_sel[0]
      && !s.regs.dual && s.regs.rise[0] == 4'h0) |-> ##[2:3] s.seq_on[0])
      else $error("zero rise delay not honoured");
   a_reg_direct: assert property ((s.regs.on[2] && !s.regs.pin_sel[2] && s.clean.supply_ok
      && !s.soft_pend && !s.clean.thermal_sd && !s.clean.overvoltage && !(drive.enable[2]
      && s.clean.low[2])) |=> drive.enable[2])
      else $error("register enable was delayed");
   a_oc_sticky: assert property ((s.clean.overcurrent[0] && !s.regs.mask[MSK_OC_LSB]
      && s.clean.supply_ok && !s.soft_pend) |=> s.regs.flags[FLG_OC_LSB] [*1])
      else $error("overcurrent flag not held");
   a_twarn_hold: assert property ((s.clean.thermal_warn && !s.regs.mask[MSK_TWARN]
      && s.clean.supply_ok && !s.soft_pend) |=> s.regs.flags[FLG_TWARN])
      else $error("thermal warning flag cleared while warm");
   a_dual_follow: assert property ((s.regs.dual && s.clean.supply_ok && !s.soft_pend)
      |=> drive.buck_code[1] == $past(s.regs.buck_code[0]))
      else $error("slave phase ignored master voltage");
   a_fall_off: assert property ((!s.en_q && s.clean.en == s.en_q
      && s.elapsed >= DELAY_TICKS[s.regs.fall[4]]) |=> !s.seq_on[4])
      else $error("aux output not dropped after fall delay");
endmodule : esf_top

// ===== esf_host.sv
// Host model: Avalon-MM master and enable pin driver for the sequencer.
// Assumes one clock; the bench calls its tasks right after a rising edge.
module esf_host (
   // Clock
   input wire logic clk,
   // Avalon-MM master
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Enable pin
   output logic en
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hf;
      en = 1'b0;
   end

   task automatic pin(input logic v);
      en <= v;
   endtask : pin

   // Holds the request until waitrequest is sampled low, then lets an edge pass
   // Waits as long as it takes; only the bench timeout ends a stuck access
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Released data is scrambled so the slave cannot lean on stale values
      writedata <= ~d;
      @(posedge clk);
   endtask : xfer
endmodule : esf_host

// ===== esf_top_tb.sv
// Self-checking bench for the enable sequencer and fault flags.
// Assumes shortened timebase: 16 cycles per tick, 20 cycles of short debounce.
module esf_top_tb;
   import esf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic en;
   esf_sense_t mon;
   esf_sense_t sense;
   logic otp_reset_mask = 1'b0;
   esf_drive_t drive;
   logic irq_low_pin;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] q;
   logic [5:0] on6;

   assign sense = {en, mon[15:0]};
   assign on6 = {drive.aux_output_b, drive.aux_output_a, drive.enable};

   esf_host esf_host_i (.clk(clk), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .en(en));

   esf_top #(.TICK_CYCLES(16'h0010), .SHORT_CYCLES(16'h0014)) esf_top_i (.clk(clk),
      .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .sense(sense), .otp_reset_mask(otp_reset_mask),
      .drive(drive), .irq_low_pin(irq_low_pin));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic conclude();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   // Far above the several hundred cycles the scenarios need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         $display("[ERR] %0t run timed out", $time);
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      esf_host_i.xfer(1'b1, a, d, 4'hf, x);
   endtask : wr

   task automatic wrb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] x;
      esf_host_i.xfer(1'b1, a, d, be, x);
   endtask : wrb

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      esf_host_i.xfer(1'b0, a, 32'h0, 4'hf, d);
   endtask : rd

   task automatic t_reset();
      rd(ADDR_FLAGS, q);
      chk(q, 32'h2000, "reset flag after power-up");
      chk({31'h0, irq_low_pin}, 32'h0, "irq with flag");
      wr(ADDR_FLAGS, 32'h2000);
      rd(ADDR_FLAGS, q);
      chk(q, 32'h0, "flag clear");
      tick(3);
      chk({31'h0, irq_low_pin}, 32'h1, "irq released");
      rd(8'h20, q);
      chk(q, 32'h0, "unmapped read");
   endtask : t_reset

   task automatic t_regon();
      wr(ADDR_VOLT, 32'h0a15c35a);
      wr(ADDR_CTRL, 32'h0000000d);
      tick(1);
      chk({26'h0, on6}, 32'h0d, "register enable at once");
      chk({24'h0, drive.buck_code[0]}, 32'h5a, "buck code");
      chk({27'h0, drive.lin_code[0]}, 32'h15, "linear code");
      wr(ADDR_CTRL, 32'h0);
      tick(1);
      chk({26'h0, on6}, 32'h0, "register disable at once");
   endtask : t_regon

   task automatic t_pin();
      wr(ADDR_RISE, 32'h00020501);
      wr(ADDR_FALL, 32'h00010004);
      // Buck1 has pin select but no on bit, so the pin never reaches it
      wr(ADDR_CTRL, 32'h00001715);
      chk({26'h0, on6}, 32'h0, "pin low keeps off");
      esf_host_i.pin(1'b1);
      tick(45);
      chk({26'h0, on6}, 32'h11, "buck0 and aux a up");
      tick(15);
      chk({26'h0, on6}, 32'h11, "linear0 still waiting");
      tick(35);
      chk({26'h0, on6}, 32'h15, "linear0 up");
      chk({24'h0, drive.buck_code[0]}, 32'h5a, "pin buck code");
      esf_host_i.pin(1'b0);
      tick(30);
      chk({26'h0, on6}, 32'h01, "linear0 and aux a down");
      tick(15);
      chk({26'h0, on6}, 32'h01, "buck0 still on");
      tick(35);
      chk({26'h0, on6}, 32'h0, "all down");
   endtask : t_pin

   task automatic t_glitch();
      esf_host_i.pin(1'b1);
      tick(30);
      esf_host_i.pin(1'b0);
      tick(15);
      chk({26'h0, on6}, 32'h01, "pending aux rise dropped");
      tick(105);
      chk({26'h0, on6}, 32'h0, "pending rise dropped");
   endtask : t_glitch

   task automatic t_soft();
      esf_host_i.pin(1'b1);
      tick(100);
      chk({26'h0, on6}, 32'h15, "sequenced on");
      wr(ADDR_RESET, 32'h2);
      wr(ADDR_RESET, 32'h3);
      tick(1);
      chk({26'h0, on6}, 32'h0, "soft reset off");
      tick(10);
      rd(ADDR_CTRL, q);
      chk(q, 32'h0, "ctrl default");
      rd(ADDR_RESET, q);
      chk(q, 32'h0, "trigger self clears, mask reloaded");
      rd(ADDR_FLAGS, q);
      chk(q, 32'h2000, "reset flag after soft reset");
      wr(ADDR_FLAGS, 32'h3fff);
   endtask : t_soft

   task automatic t_faults();
      mon.overcurrent[1] <= 1'b1;
      tick(8);
      rd(ADDR_STATUS, q);
      chk(q & 32'h7f, 32'h2, "overcurrent live");
      wr(ADDR_FLAGS, 32'h2);
      rd(ADDR_FLAGS, q);
      chk(q, 32'h2, "clear fails while active");
      mon.overcurrent[1] <= 1'b0;
      tick(8);
      wr(ADDR_FLAGS, 32'h2);
      rd(ADDR_FLAGS, q);
      chk(q, 32'h0, "clear after limit ends");
      wr(ADDR_CTRL, 32'h3f);
      tick(1);
      chk({26'h0, on6}, 32'h3f, "all on");
      mon.thermal_sd <= 1'b1;
      tick(8);
      chk({26'h0, on6}, 32'h0, "thermal shutdown off");
      wr(ADDR_FLAGS, 32'h200);
      rd(ADDR_FLAGS, q);
      chk(q & 32'h200, 32'h200, "shutdown flag persists");
      mon.thermal_sd <= 1'b0;
      tick(8);
      chk({26'h0, on6}, 32'h3f, "restart from registers");
      wr(ADDR_FLAGS, 32'h3fff);
      mon.low[0] <= 1'b1;
      tick(30);
      chk({31'h0, drive.enable[0]}, 32'h0, "short disables buck0");
      rd(ADDR_FLAGS, q);
      chk(q & 32'h10, 32'h10, "buck0 short flag");
      mon.low[0] <= 1'b0;
      wr(ADDR_FLAGS, 32'h3fff);
   endtask : t_faults

   task automatic t_uvlo();
      mon.supply_ok <= 1'b0;
      tick(8);
      chk({26'h0, on6}, 32'h0, "undervoltage off");
      rd(ADDR_CTRL, q);
      chk(q, 32'h0, "undervoltage defaults");
      mon.supply_ok <= 1'b1;
      tick(12);
      rd(ADDR_FLAGS, q);
      chk(q, 32'h2000, "reset flag after recovery");
      chk({31'h0, irq_low_pin}, 32'h0, "irq low");
   endtask : t_uvlo

   task automatic t_flags();
      wr(ADDR_FLAGS, 32'h3fff);
      wr(ADDR_MASK, 32'h22);
      mon.good[0] <= 1'b1;
      mon.overcurrent <= 4'h3;
      mon.thermal_warn <= 1'b1;
      tick(8);
      rd(ADDR_STATUS, q);
      chk(q, 32'h93, "live status");
      wr(ADDR_FLAGS, 32'h100);
      rd(ADDR_FLAGS, q);
      chk(q, 32'h101, "masked sources clear, warning held");
      mon.good[0] <= 1'b0;
      mon.overcurrent <= 4'h0;
      mon.thermal_warn <= 1'b0;
      tick(8);
      rd(ADDR_FLAGS, q);
      chk(q, 32'h901, "good fall flag");
      wr(ADDR_FLAGS, 32'h3fff);
      wr(ADDR_CTRL, 32'h3f);
      mon.overvoltage <= 1'b1;
      tick(8);
      chk({26'h0, on6}, 32'h0, "overvoltage off");
      wr(ADDR_FLAGS, 32'h400);
      rd(ADDR_FLAGS, q);
      chk(q & 32'h400, 32'h400, "overvoltage flag persists");
      mon.overvoltage <= 1'b0;
      tick(8);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_FLAGS, 32'h3fff);
      otp_reset_mask <= 1'b1;
      wr(ADDR_RESET, 32'h1);
      tick(10);
      rd(ADDR_RESET, q);
      chk(q, 32'h2, "mask reloaded from otp");
      rd(ADDR_FLAGS, q);
      chk(q, 32'h0, "reset flag masked");
      otp_reset_mask <= 1'b0;
   endtask : t_flags

   task automatic t_dual();
      esf_host_i.pin(1'b0);
      tick(10);
      wr(ADDR_VOLT, 32'h0a15c35a);
      wrb(ADDR_VOLT, 32'hffff11ff, 4'h2);
      rd(ADDR_VOLT, q);
      chk(q, 32'h0a15115a, "byte lane merge");
      wr(ADDR_CTRL, 32'h00010101);
      esf_host_i.pin(1'b1);
      tick(10);
      chk({26'h0, on6}, 32'h03, "slave phase follows master pin");
      chk({24'h0, drive.buck_code[1]}, 32'h5a, "slave phase master code");
      chk({27'h0, drive.lin_code[1]}, 32'h0a, "linear1 code");
      esf_host_i.pin(1'b0);
      tick(10);
      chk({26'h0, on6}, 32'h0, "both phases off");
      wr(ADDR_CTRL, 32'h0);
   endtask : t_dual

   initial begin
      mon = '0;
      mon.supply_ok = 1'b1;
      tick(10);
      resetn <= 1'b1;
      tick(20);
      t_reset();
      t_regon();
      t_pin();
      t_glitch();
      t_soft();
      wr(ADDR_RISE, 32'h00020501);
      t_faults();
      t_uvlo();
      t_flags();
      t_dual();
      conclude();
   end
endmodule : esf_top_tb
